// ===== verilog/owc_option_config.sv
// Option word configuration: latches programmed options and applies them.
// Assumes fuse, pin and detector inputs are asynchronous to clock_i.
//
// Behaviour
// [R01] Noise filter limits instruction clock to /4../8
// [R02] Filter off allows divisions /1 through /8
// [R03] Instruction cycle is 1,2,4,8 high clocks
// [R04] Divide-by-one with filter on is invalid
// [R05] RC option turns crystal output into port
// [R06] Always-on watchdog runs in low-power modes
// [R07] Enabled watchdog halts in sleep; disabled never
// [R08] Reset pin is reset or input-only port
// [R09] Low/mid option resets below lower threshold
// [R10] Mid option drives lower low-voltage flag
// [R11] High option resets below mid threshold
// [R12] High option drives upper low-voltage flag
// [R13] Security option enables ROM code protection
// [R14] Slow mode runs low clock divided four
// [R15] Noisy systems should use filter, always-on
// [R16] Options sampled in reset, then frozen
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
module owc_option_config
  import owc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Programmed option word
  input wire logic [OPT_W-1:0] option_word_i,
  // Pins and supply detector
  input wire logic low_clk_i,
  input wire logic reset_pin_n_i,
  input wire logic crystal_output_pin_i,
  output logic crystal_output_pin_o,
  output logic crystal_output_pin_oe_o,
  input wire logic vdd_below_low_i,
  input wire logic vdd_below_mid_i,
  input wire logic vdd_below_high_i,
  // Core side
  input wire logic port1_bit4_out_i,
  input wire logic port1_bit4_oe_i,
  output logic port1_bit4_in_o,
  output logic port1_bit5_input_o,
  output logic reset_pin_pullup_o,
  output logic osc_feedback_en_o,
  output logic [1:0] high_clk_sel_o,
  output logic instr_tick_o,
  output logic wdt_run_o,
  output logic chip_reset_req_o,
  output logic low_voltage_flag_lower_o,
  output logic low_voltage_flag_upper_o,
  output logic rom_protect_o,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Input synchronisers
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic low_clk_d_r;
  logic [SYNC_W-1:0] async_in;

  assign async_in = {vdd_below_high_i, vdd_below_mid_i, vdd_below_low_i, crystal_output_pin_i,
                     reset_pin_n_i, low_clk_i, option_word_i};

  always_ff @(posedge clock_i) begin
    sync1_r <= async_in;
    sync2_r <= sync1_r;
    low_clk_d_r <= sync2_r[OPT_W];
  end

  logic [OPT_W-1:0] opt_s;
  logic low_clk_s;
  logic reset_pin_n_s;
  logic crystal_output_pin_s;
  logic below_low_s;
  logic below_mid_s;
  logic below_high_s;

  assign opt_s = sync2_r[OPT_W-1:0];
  assign low_clk_s = sync2_r[OPT_W];
  assign reset_pin_n_s = sync2_r[OPT_W+1];
  assign crystal_output_pin_s = sync2_r[OPT_W+2];
  assign below_low_s = sync2_r[OPT_W+3];
  assign below_mid_s = sync2_r[OPT_W+4];
  assign below_high_s = sync2_r[OPT_W+5];

  // Option latch
  logic [OPT_W-1:0] opt_r;
  logic [OPT_W-1:0] opt_nxt;

  always_comb begin
    opt_nxt = opt_r;
    if (!rst_n_i) begin
      opt_nxt = opt_s; // R16
    end
  end

  always_ff @(posedge clock_i) begin
    opt_r <= opt_nxt;
  end

  logic nf_en;
  logic [1:0] div_code;
  logic [1:0] hclk_code;
  logic [1:0] wdt_code;
  logic rstpin_is_port;
  logic [1:0] lv_code;

  assign nf_en = opt_r[OPT_NF_POS];
  assign div_code = opt_r[OPT_DIV_POS +: 2];
  assign hclk_code = opt_r[OPT_HCLK_POS +: 2];
  assign wdt_code = opt_r[OPT_WDT_POS +: 2];
  assign rstpin_is_port = opt_r[OPT_RSTPIN_POS];
  assign lv_code = opt_r[OPT_LV_POS +: 2];

  // Mode register and derived controls
  logic [2:0] mode_r;
  logic slow_mode;
  logic sleep_mode;

  assign slow_mode = mode_r[MODE_SLOW_POS];
  assign sleep_mode = mode_r[MODE_GREEN_POS] | mode_r[MODE_PDOWN_POS];

  logic cfg_invalid;
  logic [1:0] div_eff;
  logic [2:0] high_ratio_m1;

  always_comb begin
    cfg_invalid = nf_en && (div_code == DIV_1 || div_code == DIV_2); // R04
    div_eff = cfg_invalid ? DIV_4 : div_code; // R01
    case (div_eff)
      DIV_1: high_ratio_m1 = 3'h0; // R02 R03
      DIV_2: high_ratio_m1 = 3'h1;
      DIV_4: high_ratio_m1 = 3'h3;
      DIV_8: high_ratio_m1 = 3'h7;
      default: high_ratio_m1 = 3'h7;
    endcase
  end

  logic high_tick;
  logic low_tick;
  logic low_step;

  assign low_step = low_clk_s & ~low_clk_d_r;

  owc_clk_div u_high_div (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .step_i(~slow_mode & ~sleep_mode),
    .ratio_m1_i(high_ratio_m1),
    .tick_o(high_tick)
  );

  owc_clk_div u_low_div (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .step_i(slow_mode & ~sleep_mode & low_step),
    .ratio_m1_i(SLOW_RATIO_M1),
    .tick_o(low_tick)
  );

  // Applied outputs
  logic crystal_output_pin_port_r;
  logic p14_in_r;
  logic p14_out_r;
  logic p14_oe_r;
  logic p15_r;
  logic wdt_run_r;
  logic ext_reset_r;
  logic lv_reset_r;
  logic flag_lower_r;
  logic flag_upper_r;
  logic protect_r;
  logic tick_r;
  logic crystal_output_pin_port_nxt;
  logic p14_in_nxt;
  logic p14_out_nxt;
  logic p14_oe_nxt;
  logic p15_nxt;
  logic wdt_run_nxt;
  logic ext_reset_nxt;
  logic lv_reset_nxt;
  logic flag_lower_nxt;
  logic flag_upper_nxt;
  logic protect_nxt;
  logic tick_nxt;

  always_comb begin
    crystal_output_pin_port_nxt = (hclk_code == HCLK_RC); // R05
    p14_in_nxt = crystal_output_pin_port_nxt & crystal_output_pin_s;
    p14_out_nxt = crystal_output_pin_port_nxt & port1_bit4_out_i;
    p14_oe_nxt = crystal_output_pin_port_nxt & port1_bit4_oe_i; // R05
    p15_nxt = rstpin_is_port & reset_pin_n_s; // R08
    ext_reset_nxt = ~rstpin_is_port & ~reset_pin_n_s; // R08
    case (wdt_code)
      WDT_DISABLE: wdt_run_nxt = 1'b0; // R07
      WDT_ENABLE: wdt_run_nxt = ~sleep_mode; // R07
      default: wdt_run_nxt = 1'b1; // R06
    endcase
    case (lv_code)
      LV_LOW: lv_reset_nxt = below_low_s; // R09
      LV_MID: lv_reset_nxt = below_low_s; // R09
      default: lv_reset_nxt = below_mid_s; // R11
    endcase
    flag_lower_nxt = (lv_code == LV_MID) & below_mid_s; // R10
    flag_upper_nxt = (lv_code != LV_LOW) & (lv_code != LV_MID) & below_high_s; // R12
    protect_nxt = opt_r[OPT_SEC_POS]; // R13
    tick_nxt = slow_mode ? low_tick : high_tick; // R14
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      crystal_output_pin_port_r <= 1'b0;
      p14_in_r <= 1'b0;
      p14_out_r <= 1'b0;
      p14_oe_r <= 1'b0;
      p15_r <= 1'b0;
      wdt_run_r <= 1'b0;
      ext_reset_r <= 1'b0;
      lv_reset_r <= 1'b0;
      flag_lower_r <= 1'b0;
      flag_upper_r <= 1'b0;
      protect_r <= 1'b1;
      tick_r <= 1'b0;
    end else begin
      crystal_output_pin_port_r <= crystal_output_pin_port_nxt;
      p14_in_r <= p14_in_nxt;
      p14_out_r <= p14_out_nxt;
      p14_oe_r <= p14_oe_nxt;
      p15_r <= p15_nxt;
      wdt_run_r <= wdt_run_nxt;
      ext_reset_r <= ext_reset_nxt;
      lv_reset_r <= lv_reset_nxt;
      flag_lower_r <= flag_lower_nxt;
      flag_upper_r <= flag_upper_nxt;
      protect_r <= protect_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign crystal_output_pin_o = p14_out_r;
  assign crystal_output_pin_oe_o = p14_oe_r;
  assign port1_bit4_in_o = p14_in_r;
  assign osc_feedback_en_o = ~crystal_output_pin_port_r;
  assign high_clk_sel_o = hclk_code;
  assign port1_bit5_input_o = p15_r;
  assign reset_pin_pullup_o = ~rstpin_is_port; // R08
  assign instr_tick_o = tick_r;
  assign wdt_run_o = wdt_run_r;
  assign chip_reset_req_o = ext_reset_r | lv_reset_r;
  assign low_voltage_flag_lower_o = flag_lower_r;
  assign low_voltage_flag_upper_o = flag_upper_r;
  assign rom_protect_o = protect_r;

  // AXI4-Lite slave
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_held_nxt;
  logic w_held_nxt;
  logic [ADDR_W-1:0] awaddr_nxt;
  logic [31:0] wdata_nxt;
  logic wstrb0_nxt;
  logic bvalid_nxt;
  logic [1:0] bresp_nxt;
  logic rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;
  logic [2:0] mode_nxt;
  logic [31:0] status_word;

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready = ~w_held_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;

  always_comb begin
    status_word = {25'h0000000, slow_mode, cfg_invalid, wdt_run_r, ext_reset_r, lv_reset_r,
                   flag_upper_r, flag_lower_r};
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    mode_nxt = mode_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (aw_held_r && w_held_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case (awaddr_r)
        REG_MODE: begin
          if (wstrb0_r) begin
            mode_nxt = wdata_r[2:0];
          end
        end
        REG_OPTION, REG_STATUS: bresp_nxt = RESP_OKAY; // R16
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
        REG_OPTION: rdata_nxt = {21'h000000, opt_r};
        REG_STATUS: rdata_nxt = status_word;
        REG_MODE: rdata_nxt = {29'h00000000, mode_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
      mode_r <= MODE_RESET_VAL;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      mode_r <= mode_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule : owc_option_config

// ===== verilog/owc_pkg.sv
// Constants for the option word configuration block.
// Assumes a single 100 MHz clock and AXI4-Lite register access.
package owc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SYNC_W = 17;

  // Option word field positions
  localparam int unsigned OPT_W = 11;
  localparam int unsigned OPT_NF_POS = 0;
  localparam int unsigned OPT_DIV_POS = 1;
  localparam int unsigned OPT_HCLK_POS = 3;
  localparam int unsigned OPT_WDT_POS = 5;
  localparam int unsigned OPT_RSTPIN_POS = 7;
  localparam int unsigned OPT_LV_POS = 8;
  localparam int unsigned OPT_SEC_POS = 10;
  localparam logic [OPT_W-1:0] OPT_RESET_VAL = 11'h000;

  // Instruction clock division codes
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_2 = 2'h1;
  localparam logic [1:0] DIV_4 = 2'h2;
  localparam logic [1:0] DIV_8 = 2'h3;

  // High clock source codes
  localparam logic [1:0] HCLK_RC = 2'h0;
  localparam logic [1:0] HCLK_32K = 2'h1;
  localparam logic [1:0] HCLK_12M = 2'h2;
  localparam logic [1:0] HCLK_4M = 2'h3;

  // Watchdog mode codes
  localparam logic [1:0] WDT_DISABLE = 2'h0;
  localparam logic [1:0] WDT_ENABLE = 2'h1;
  localparam logic [1:0] WDT_ALWAYS_ON = 2'h2;

  // Low voltage option codes
  localparam logic [1:0] LV_LOW = 2'h0;
  localparam logic [1:0] LV_MID = 2'h1;
  localparam logic [1:0] LV_HIGH = 2'h2;

  // Slow mode instruction clock ratio minus one
  localparam logic [2:0] SLOW_RATIO_M1 = 3'h3;

  // Register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_OPTION = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MODE = 8'h08;
  localparam logic [2:0] MODE_RESET_VAL = 3'h0;
  localparam int unsigned MODE_SLOW_POS = 0;
  localparam int unsigned MODE_GREEN_POS = 1;
  localparam int unsigned MODE_PDOWN_POS = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : owc_pkg

// ===== verilog/owc_clk_div.sv
// Step divider giving a one-cycle tick every ratio steps.
// Assumes step_i and ratio_m1_i come from logic on clock_i.
`timescale 1ns/100ps
module owc_clk_div (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic [2:0] ratio_m1_i,
  output logic tick_o
);

  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (step_i) begin
      if (cnt_r >= ratio_m1_i) begin
        cnt_nxt = 3'h0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule : owc_clk_div

// ===== verif/owc_option_config_asserts.sv
// Checker for the option word configuration block.
// Assumes the option word is steady while reset is held.
`timescale 1ns/100ps
module owc_option_config_asserts
  import owc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [OPT_W-1:0] option_word_i,
  input wire logic vdd_below_low_i,
  input wire logic vdd_below_mid_i,
  input wire logic vdd_below_high_i,
  input wire logic instr_tick_o,
  input wire logic wdt_run_o,
  input wire logic chip_reset_req_o,
  input wire logic low_voltage_flag_lower_o,
  input wire logic low_voltage_flag_upper_o,
  input wire logic rom_protect_o,
  input wire logic reset_pin_pullup_o,
  input wire logic osc_feedback_en_o,
  input wire logic crystal_output_pin_oe_o,
  input wire logic port1_bit5_input_o,
  input wire logic [1:0] high_clk_sel_o
);
  logic [OPT_W-1:0] opt_r;
  logic [1:0] up_r;
  logic live;
  logic lv_hi;
  logic lv_mid;
  // Own copy of the options, plus a settle count after release
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      opt_r <= option_word_i;
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  assign live = up_r == 2'h3;
  assign lv_hi = opt_r[OPT_LV_POS+1];
  assign lv_mid = opt_r[OPT_LV_POS +: 2] == LV_MID;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_ROM_PROT: assert property (live |-> rom_protect_o == opt_r[OPT_SEC_POS])
    else $error("rom protect differs from option");
  AST_RST_PIN: assert property (live |-> reset_pin_pullup_o == !opt_r[OPT_RSTPIN_POS]
    && (opt_r[OPT_RSTPIN_POS] || !port1_bit5_input_o)) else $error("reset pin use wrong");
  AST_CRYSTAL_OUTPUT_PIN: assert property (live |-> osc_feedback_en_o == (opt_r[OPT_HCLK_POS +: 2] != HCLK_RC)
    && (!osc_feedback_en_o || !crystal_output_pin_oe_o)) else $error("crystal pin use wrong");
  AST_FROZEN: assert property (live |-> high_clk_sel_o == opt_r[OPT_HCLK_POS +: 2])
    else $error("clock source left latched option");
  AST_WDT_OFF: assert property (live && opt_r[OPT_WDT_POS +: 2] == WDT_DISABLE |-> !wdt_run_o)
    else $error("disabled watchdog runs");
  AST_TICK_NF: assert property (instr_tick_o && opt_r[OPT_NF_POS] |=> !instr_tick_o [*3])
    else $error("ticks too close with filter");
  AST_LV_LOW: assert property ((live && !lv_hi && vdd_below_low_i) [*4] |-> chip_reset_req_o)
    else $error("no reset below lower threshold");
  AST_LV_HI: assert property ((live && lv_hi && vdd_below_mid_i) [*4] |-> chip_reset_req_o)
    else $error("no reset below higher threshold");
  AST_FLAG_LO: assert property ((live && lv_mid && vdd_below_mid_i) [*4] |-> low_voltage_flag_lower_o)
    else $error("lower flag missing");
  AST_FLAG_UP: assert property ((live && lv_hi && vdd_below_high_i) [*4] |-> low_voltage_flag_upper_o)
    else $error("upper flag missing");
  cover property (instr_tick_o && opt_r[OPT_NF_POS]);
  cover property (live && chip_reset_req_o);
  cover property (live && low_voltage_flag_upper_o);
endmodule : owc_option_config_asserts

bind owc_option_config owc_option_config_asserts i_owc_option_config_asserts (.*);

// ===== verif/tb_option_word_configuration.sv
// Testbench for the option word configuration block.
// Assumes owc_pkg, the design and its checker compile first.
`timescale 1ns/100ps
module tb_option_word_configuration;
  import owc_pkg::*;
  logic clock_i, rst_n_i, low_clk_i, reset_pin_n_i, crystal_output_pin_i, vdd_below_low_i, vdd_below_mid_i;
  logic vdd_below_high_i, port1_bit4_out_i, port1_bit4_oe_i, crystal_output_pin_o, crystal_output_pin_oe_o;
  logic port1_bit4_in_o, port1_bit5_input_o, reset_pin_pullup_o, osc_feedback_en_o, instr_tick_o, wdt_run_o;
  logic chip_reset_req_o, low_voltage_flag_lower_o, low_voltage_flag_upper_o, rom_protect_o, pin_ext;
  logic [OPT_W-1:0] option_word_i, w;
  logic [1:0] high_clk_sel_o, s_axi_bresp, s_axi_rresp, rsp;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  int error_cnt, num_checks, ticks, t0, i;

  owc_option_config i_owc_option_config (.*);

  // Shared pin: the block wins while it drives
  assign crystal_output_pin_i = crystal_output_pin_oe_o ? crystal_output_pin_o : pin_ext;

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (instr_tick_o === 1'b1) ticks <= ticks + 1;
  end

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic fail_wait;
    $display("Error at %0t: no bus answer", $time);
    error_cnt++;
    report_and_stop();
  endtask : fail_wait

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc

  task automatic boot(input logic [OPT_W-1:0] wd);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    option_word_i <= wd;
    {vdd_below_low_i, vdd_below_mid_i, vdd_below_high_i, low_clk_i, port1_bit4_oe_i} <= '0;
    reset_pin_n_i <= 1'b1;
    cyc(16);
    rst_n_i <= 1'b1;
    cyc(3);
  endtask : boot

  task automatic tick_chk(input int n, input int exp);
    t0 = ticks;
    cyc(n);
    check(ticks - t0, exp);
  endtask : tick_chk

  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) fail_wait();
  endtask : axi_wr

  task automatic axi_rd(input logic [ADDR_W-1:0] a);
    int n;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) fail_wait();
  endtask : axi_rd

  initial begin
    {rst_n_i, low_clk_i, pin_ext, vdd_below_low_i, vdd_below_mid_i, vdd_below_high_i} = '0;
    {port1_bit4_out_i, port1_bit4_oe_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {error_cnt, num_checks, ticks} = '0;
    reset_pin_n_i = 1'b1;
    option_word_i = '0;
    // RC clock, divide by one, reset pin as port
    w = {1'b0, LV_LOW, 1'b1, WDT_ENABLE, HCLK_RC, DIV_1, 1'b0};
    boot(w);
    tick_chk(48, 48);
    pin_ext <= 1'b1;
    reset_pin_n_i <= 1'b0;
    cyc(4);
    check({crystal_output_pin_oe_o, osc_feedback_en_o, port1_bit4_in_o}, 3'h1);
    check({port1_bit5_input_o, reset_pin_pullup_o, chip_reset_req_o}, 3'h0);
    port1_bit4_oe_i <= 1'b1;
    reset_pin_n_i <= 1'b1;
    cyc(5);
    check({crystal_output_pin_oe_o, crystal_output_pin_o, port1_bit4_in_o}, 3'h4);
    check({port1_bit5_input_o, rom_protect_o, wdt_run_o}, 3'h5);
    port1_bit4_out_i <= 1'b1;
    cyc(5);
    check({crystal_output_pin_o, port1_bit4_in_o}, 2'h3);
    vdd_below_low_i <= 1'b1;
    cyc(4);
    check(chip_reset_req_o, 1'b1);
    vdd_below_low_i <= 1'b0;
    axi_rd(8'h0C);
    check({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    axi_wr(REG_MODE, 32'h2);
    cyc(2);
    check(wdt_run_o, 1'b0);
    axi_wr(REG_MODE, 32'h1);
    cyc(2);
    check(wdt_run_o, 1'b1);
    tick_chk(16, 0);
    t0 = ticks;
    repeat (16) begin
      low_clk_i <= 1'b1;
      cyc(2);
      low_clk_i <= 1'b0;
      cyc(2);
    end
    cyc(6);
    check(ticks - t0, 4);
    option_word_i <= ~w;
    axi_wr(REG_OPTION, 32'h7FF);
    check(rsp, RESP_OKAY);
    cyc(4);
    axi_rd(REG_OPTION);
    check({rd[30:0], osc_feedback_en_o}, {20'h0, w, 1'b0});
    // Filter on with divide by one is refused
    w = {1'b1, LV_MID, 1'b0, WDT_ALWAYS_ON, HCLK_12M, DIV_1, 1'b1};
    boot(w);
    tick_chk(48, 12);
    axi_rd(REG_STATUS);
    check(rd[5], 1'b1);
    check({rom_protect_o, reset_pin_pullup_o, osc_feedback_en_o, crystal_output_pin_oe_o}, 4'hE);
    vdd_below_mid_i <= 1'b1;
    cyc(4);
    check({low_voltage_flag_lower_o, low_voltage_flag_upper_o, chip_reset_req_o}, 3'h4);
    vdd_below_low_i <= 1'b1;
    cyc(4);
    check(chip_reset_req_o, 1'b1);
    {vdd_below_low_i, vdd_below_mid_i, reset_pin_n_i} <= 3'h0;
    cyc(4);
    check({chip_reset_req_o, port1_bit5_input_o}, 2'h2);
    axi_wr(REG_MODE, 32'h4);
    cyc(2);
    check(wdt_run_o, 1'b1);
    // Every division and clock source code
    for (i = 0; i < 4; i++) begin
      w = {1'b0, LV_HIGH, 1'b0, WDT_DISABLE, 2'(i), 2'(i), i > 1};
      boot(w);
      tick_chk(48, 48 >> i);
      check({high_clk_sel_o, osc_feedback_en_o, wdt_run_o}, {2'(i), i != 0, 1'b0});
    end
    vdd_below_mid_i <= 1'b1;
    cyc(4);
    check({chip_reset_req_o, low_voltage_flag_lower_o}, 2'h2);
    {vdd_below_mid_i, vdd_below_high_i} <= 2'h1;
    cyc(4);
    check({low_voltage_flag_upper_o, chip_reset_req_o}, 2'h2);
    report_and_stop();
  end
endmodule : tb_option_word_configuration
